// ===== sro_readout.sv
// serial readout top: strobe capture, conversion timing, axi4-lite slave
// assumes core_clk at 125 MHz and a host shift clock that may stop between frames
`include "sro_map.svh"
module sro_readout
    import sro_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic core_ce,
    // pins
    input wire logic convert_start_p,
    input wire logic convert_start_n,
    input wire logic power_down_n,
    input wire logic pattern_select,
    input wire logic dual_lane_select,
    input wire logic [15:0] sampled_code,
    input wire logic shift_clk,
    output logic echoed_data_clock,
    output logic echoed_data_clock_oe,
    output logic lane_a_data,
    output logic lane_a_oe,
    output logic lane_b_data,
    output logic lane_b_oe,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cnv_legs;
    logic power_s;
    logic pattern_s;
    logic dual_s;
    logic [15:0] code_s;

    // both strobe legs, mode pins and the sample code
    sro_sync #(.W(2)) u_sync_cnv (
        .clk(core_clk),
        .rst_n(nrst),
        .din({convert_start_p, convert_start_n}),
        .dout(cnv_legs)
    );
    sro_sync #(.W(3)) u_sync_mode (
        .clk(core_clk),
        .rst_n(nrst),
        .din({power_down_n, pattern_select, dual_lane_select}),
        .dout({power_s, pattern_s, dual_s})
    );
    sro_sync #(.W(16)) u_sync_code (
        .clk(core_clk),
        .rst_n(nrst),
        .din(sampled_code),
        .dout(code_s)
    );

    // ----------------------------------------------------------------
    // strobe decode and edge detect
    // ----------------------------------------------------------------
    logic cnv_level;
    logic cnv_prev_q;
    logic start_edge;

    // high leg above low leg; a grounded low leg leaves the high leg alone
    assign cnv_level = cnv_legs[1] & ~cnv_legs[0]; // RULE_11
    assign start_edge = cnv_level & ~cnv_prev_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnv_prev_q <= 1'b0;
        end else if (core_ce) begin
            cnv_prev_q <= cnv_level;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic sw_enable;
    logic use_pattern;
    logic powered;

    assign sw_enable = ctrl_q[`SRO_CTRL_ENABLE_BIT];
    assign use_pattern = pattern_s | ctrl_q[`SRO_CTRL_FORCE_PAT_BIT]; // RULE_10
    assign powered = power_s; // RULE_09

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    sro_state_t state_q;
    sro_state_t state_d;
    logic [3:0] wait_q;
    logic [3:0] wait_d;
    logic [15:0] hold_q;
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic frame_clr_q;
    logic dual_q;
    logic [31:0] count_q;
    logic take_sample;
    logic conv_done;

    localparam logic [3:0] WAIT_LOAD = 4'(`SRO_CONV_WAIT_CYC - 1);

    assign take_sample = start_edge & powered & sw_enable; // RULE_01
    assign conv_done = (state_q == SRO_CONVERT) && (wait_q == 4'h0); // RULE_02
    assign word_d = use_pattern ? `SRO_TEST_PATTERN : hold_q; // RULE_10

    // next state, a new strobe starts a conversion from idle or ready; a strobe during convert is ignored
    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        case (state_q)
            SRO_IDLE: begin
                if (take_sample) begin
                    state_d = SRO_CONVERT;
                    wait_d = WAIT_LOAD;
                end
            end
            SRO_CONVERT: begin
                if (conv_done) begin
                    state_d = SRO_READY;
                end else begin
                    wait_d = wait_q - 4'h1;
                end
            end
            SRO_READY: begin
                if (take_sample) begin
                    state_d = SRO_CONVERT;
                    wait_d = WAIT_LOAD;
                end
            end
            default: begin
                state_d = SRO_IDLE;
                wait_d = 4'h0;
            end
        endcase
        if (!powered) begin
            state_d = SRO_IDLE;
            wait_d = 4'h0;
        end
    end

    // state and wait counter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SRO_IDLE;
            wait_q <= 4'h0;
        end else if (core_ce) begin
            state_q <= state_d;
            wait_q <= wait_d;
        end
    end

    // sample held at the strobe edge itself, two's complement as given
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= 16'h0000;
        end else if (core_ce && take_sample) begin
            hold_q <= code_s; // RULE_12 RULE_13
        end
    end

    // word published and shifter cleared at data ready
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            word_q <= 16'h0000;
            dual_q <= 1'b0;
            frame_clr_q <= 1'b0;
        end else if (core_ce) begin
            frame_clr_q <= conv_done;
            if (conv_done) begin
                word_q <= word_d; // RULE_02
                dual_q <= dual_s;
            end
        end
    end

    // finished conversions
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 32'h0000_0000;
        end else if (core_ce && conv_done) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // link side
    // ----------------------------------------------------------------
    logic link_on_q;
    logic lane_b_on_q;
    logic frame_rst_n;
    logic shift_a;
    logic shift_b;

    // driver enables, all off in power-down
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            link_on_q <= 1'b0;
            lane_b_on_q <= 1'b0;
        end else if (core_ce) begin
            link_on_q <= powered; // RULE_09
            lane_b_on_q <= powered & dual_s; // RULE_07 RULE_08
        end
    end

    // shifter reset between the previous frame's end and the next first edge
    assign frame_rst_n = nrst & ~frame_clr_q & link_on_q; // RULE_03 RULE_04

    // word and mode held still across the frame; a shift-side sync would lag two edges
    sro_shifter u_shifter (
        .shift_clk(shift_clk),
        .frame_rst_n(frame_rst_n),
        .word(word_q),
        .dual(dual_q),
        .lane_a_q(shift_a),
        .lane_b_q(shift_b)
    );

    // echo of the host clock, gated off in power-down
    assign echoed_data_clock = shift_clk & link_on_q; // RULE_06
    assign echoed_data_clock_oe = link_on_q;
    assign lane_a_data = shift_a;
    assign lane_b_data = shift_b;
    assign lane_a_oe = link_on_q;
    assign lane_b_oe = lane_b_on_q; // RULE_08

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_hit_ctrl;
    logic wr_mapped;
    logic [31:0] strb_mask;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_hit_ctrl = (aw_addr_q == `SRO_ADDR_CTRL);
    assign wr_mapped = wr_hit_ctrl || (aw_addr_q == `SRO_ADDR_STATUS)
        || (aw_addr_q == `SRO_ADDR_RESULT) || (aw_addr_q == `SRO_ADDR_COUNT);
    assign strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign ctrl_d = (ctrl_q & ~strb_mask) | (w_data_q & strb_mask);

    // address and data taken in either order
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (core_ce) begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (core_ce) begin
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
            s_axi_wready <= ~w_have_q & ~w_take & ~s_axi_bvalid;
        end
    end

    // register update and write response
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `SRO_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SRO_RESP_OKAY;
        end else if (core_ce) begin
            if (wr_fire) begin
                if (wr_hit_ctrl) begin
                    ctrl_q <= ctrl_d & 32'h0000_0003;
                end
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `SRO_RESP_OKAY : `SRO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic ar_take;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    logic rd_mapped;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign status_w = {27'h000_0000, use_pattern, dual_s, powered,
        (state_q == SRO_READY), (state_q == SRO_CONVERT)};
    assign rd_mapped = (s_axi_araddr == `SRO_ADDR_CTRL) || (s_axi_araddr == `SRO_ADDR_STATUS)
        || (s_axi_araddr == `SRO_ADDR_RESULT) || (s_axi_araddr == `SRO_ADDR_COUNT);
    assign rd_mux = (s_axi_araddr == `SRO_ADDR_CTRL) ? ctrl_q :
        (s_axi_araddr == `SRO_ADDR_STATUS) ? status_w :
        (s_axi_araddr == `SRO_ADDR_RESULT) ? {16'h0000, word_q} :
        (s_axi_araddr == `SRO_ADDR_COUNT) ? count_q : 32'h0000_0000;

    // one read at a time, answered the cycle after the address
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SRO_RESP_OKAY;
        end else if (core_ce) begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_mapped ? `SRO_RESP_OKAY : `SRO_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : sro_readout

// ===== sro_map.svh
// constants of the serial readout block: offsets, fields, resets, timing
// assumes a 125 MHz core clock and a host-driven shift clock
//
// Operation
// [RULE_01] a rising convert-start edge puts the sample into hold and starts a conversion; here only while the enable bit of the control register is set.
// [RULE_02] the result is ready for shifting 88 ns to 101 ns after the convert-start edge.
// [RULE_03] the host gives no rising shift edge of a frame earlier than 104 ns after its start.
// [RULE_04] the host ends the previous frame by 83 ns after the next convert-start edge.
// [RULE_05] the host supplies the shift clock and each of its cycles moves one step out.
// [RULE_06] an echoed data clock follows the shift clock so the host can latch the lanes.
// [RULE_07] with dual-lane select high each step puts one bit on lane a and one on lane b.
// [RULE_08] with dual-lane select low each step uses lane a only and lane b is switched off.
// [RULE_09] while power-down is low all logic, the serial outputs too, is shut down; here the sequencer and drivers stop but the axi4-lite slave still answers.
// [RULE_10] while pattern select is high the lanes carry a fixed pattern instead of results.
// [RULE_11] convert start takes a differential strobe or a single-ended one with the low leg grounded.
// [RULE_12] results are 16-bit two's complement; flipping the top bit gives offset binary.
// [RULE_13] the word read after a convert-start edge is the sample taken at that same edge.
// [RULE_14] the host spaces convert-start edges by 200 ns to 50000 ns.
// [RULE_15] bits leave top bit first and the host rebuilds the word on the echoed clock.
`ifndef SRO_MAP_SVH
`define SRO_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SRO_ADDR_CTRL 8'h00
`define SRO_ADDR_STATUS 8'h04
`define SRO_ADDR_RESULT 8'h08
`define SRO_ADDR_COUNT 8'h0C
`define SRO_CTRL_RESET 32'h0000_0001
`define SRO_CTRL_ENABLE_BIT 0
`define SRO_CTRL_FORCE_PAT_BIT 1
`define SRO_ST_BUSY_BIT 0
`define SRO_ST_READY_BIT 1
`define SRO_ST_POWERED_BIT 2
`define SRO_ST_DUAL_BIT 3
`define SRO_ST_PATTERN_BIT 4
`define SRO_RESP_OKAY 2'b00
`define SRO_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// data
// ----------------------------------------------------------------
`define SRO_WORD_W 16
`define SRO_TEST_PATTERN 16'hA5C3
`define SRO_STEP_W 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SRO_CORE_CLK_MHZ 125
`define SRO_CONV_MIN_NS 88
`define SRO_CONV_MAX_NS 101
`define SRO_FIRST_SHIFT_NS 104
`define SRO_LAST_PREV_SHIFT_NS 83
`define SRO_CONV_MIN_CYC ((`SRO_CONV_MIN_NS * `SRO_CORE_CLK_MHZ + 999) / 1000)
`define SRO_CONV_MAX_CYC ((`SRO_CONV_MAX_NS * `SRO_CORE_CLK_MHZ) / 1000)
`define SRO_SYNC_CYC 2
`define SRO_CONV_WAIT_CYC (`SRO_CONV_MIN_CYC - `SRO_SYNC_CYC)

`endif

// ===== sro_pkg.sv
// types of the serial readout block
// assumes sro_map.svh for all numbers
package sro_pkg;
    // conversion sequencer states
    typedef enum logic [1:0] {
        SRO_IDLE,
        SRO_CONVERT,
        SRO_READY
    } sro_state_t;
endpackage : sro_pkg

// ===== sro_sync.sv
// two-flop synchroniser for static or slow levels
// assumes the input comes from another clock domain or a pin
module sro_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : sro_sync

// ===== sro_shifter.sv
// link-side shifter, clocked by the host shift clock
// assumes word and dual mode stay still from frame clear to frame end
`include "sro_map.svh"
module sro_shifter (
    input wire logic shift_clk,
    input wire logic frame_rst_n,
    input wire logic [`SRO_WORD_W-1:0] word,
    input wire logic dual,
    output logic lane_a_q,
    output logic lane_b_q
);
    logic [`SRO_STEP_W-1:0] step_q;
    logic [`SRO_STEP_W-1:0] idx_a;
    logic [`SRO_STEP_W-1:0] idx_b;
    logic last_step;

    // bit picked for this step, top bit first
    assign idx_a = dual ? 4'hF - {step_q[2:0], 1'b0} : 4'hF - step_q; // RULE_15
    assign idx_b = 4'hE - {step_q[2:0], 1'b0};
    assign last_step = dual ? (step_q == 4'h7) : (step_q == 4'hF);

    // one step per rising shift edge, cleared before each frame
    always_ff @(posedge shift_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            step_q <= '0;
            lane_a_q <= 1'b0;
            lane_b_q <= 1'b0;
        end else begin
            lane_a_q <= word[idx_a]; // RULE_05
            lane_b_q <= dual & word[idx_b]; // RULE_07 RULE_08
            if (!last_step) begin
                step_q <= step_q + 4'h1;
            end
        end
    end
endmodule : sro_shifter

// ===== sro_readout_assertions.sv
// port-level checks of the serial readout top
// assumes one core clock domain and an async active-low reset
module sro_readout_assertions (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic power_down_n,
    input wire logic dual_lane_select,
    input wire logic shift_clk,
    input wire logic echoed_data_clock,
    input wire logic echoed_data_clock_oe,
    input wire logic lane_a_data,
    input wire logic lane_a_oe,
    input wire logic lane_b_data,
    input wire logic lane_b_oe,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // drivers follow power-down after the pin sync
    AST_PD_OFF: assert property (!power_down_n [*5] |->
        !lane_a_oe && !lane_b_oe && !echoed_data_clock_oe && !echoed_data_clock)
        else $error("link active in power down");
    AST_PD_ON: assert property (power_down_n [*5] |->
        lane_a_oe && echoed_data_clock_oe)
        else $error("link off while powered");
    // echoed clock is the shift clock while powered
    AST_ECHO: assert property (power_down_n [*5] |->
        echoed_data_clock == shift_clk)
        else $error("echo differs from shift clock");
    // lane b driver tracks the lane mode
    AST_LANEB_OFF: assert property (!dual_lane_select [*5] |-> !lane_b_oe)
        else $error("lane b on in single mode");
    AST_LANEB_ON: assert property ((dual_lane_select && power_down_n) [*5] |->
        lane_b_oe)
        else $error("lane b off in dual mode");
    // a lane rises only on a shift step
    AST_A_STEP: assert property (!$stable(lane_a_data) && lane_a_data |->
        $rose(shift_clk))
        else $error("lane a moved without shift");
    AST_B_STEP: assert property (!$stable(lane_b_data) && lane_b_data |->
        $rose(shift_clk))
        else $error("lane b moved without shift");
    // read answer one cycle after the address is taken
    AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property ($rose(lane_b_oe));
    cover property ($fell(lane_a_oe));
    cover property ($rose(lane_a_data));
endmodule : sro_readout_assertions

bind sro_readout sro_readout_assertions u_sro_chk (
    .core_clk(core_clk),
    .nrst(nrst),
    .power_down_n(power_down_n),
    .dual_lane_select(dual_lane_select),
    .shift_clk(shift_clk),
    .echoed_data_clock(echoed_data_clock),
    .echoed_data_clock_oe(echoed_data_clock_oe),
    .lane_a_data(lane_a_data),
    .lane_a_oe(lane_a_oe),
    .lane_b_data(lane_b_data),
    .lane_b_oe(lane_b_oe),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid)
);

// ===== sro_host_model.sv
// host side: convert strobe, shift clock, word rebuild
// assumes the device echoes the shift clock and shifts on its rise
module sro_host_model (
    output logic convert_start_p,
    output logic convert_start_n,
    output logic shift_clk,
    input wire logic echoed_data_clock,
    input wire logic lane_a_w,
    input wire logic lane_b_w,
    output logic [15:0] got_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic dual_m;
    initial begin
        convert_start_p = 1'b0;
        convert_start_n = 1'b0;
        shift_clk = 1'b0;
        dual_m = 1'b0;
        got_q = 16'h0000;
    end
    // rebuild the word on the echoed falling edge
    always @(negedge echoed_data_clock) begin
        if (dual_m) begin
            got_q <= {got_q[13:0], lane_a_w, lane_b_w};
        end else begin
            got_q <= {got_q[14:0], lane_a_w};
        end
    end
    // shift clock pulses, 30 ns period, still otherwise
    task automatic pulses(input int n);
        repeat (n) begin
            #15 shift_clk = 1'b1;
            #15 shift_clk = 1'b0;
        end
    endtask : pulses
    // one frame: strobe, wait out the conversion, shift the word
    task automatic frame(input logic dual, input logic diff);
        dual_m = dual;
        convert_start_n = diff;
        #10;
        convert_start_p = 1'b1;
        convert_start_n = 1'b0;
        #40;
        convert_start_p = 1'b0;
        convert_start_n = diff;
        #49.3;
        pulses(dual ? 8 : 16);
        #120;
    endtask : frame
endmodule : sro_host_model

// ===== testbench.sv
// bench of the serial readout block: axi4-lite tasks and host frames
// assumes sro_map.svh and the host model beside it
`include "sro_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, nrst = 1'b0, power_down_n = 1'b1;
    logic pattern_select = 1'b0, dual_lane_select = 1'b0;
    logic [15:0] sampled_code = 16'h0000;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic cs_p, cs_n, sclk, echo, echo_oe, la, la_oe, lb, lb_oe, la_w, lb_w;
    wire logic [15:0] got;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [15:0] codes [4] = '{16'h8001, 16'h7FFE, 16'h4B2D, 16'hD2B4};
    always #4 core_clk = ~core_clk;
    // a released lane reads as unknown
    assign la_w = la_oe ? la : 1'bx;
    assign lb_w = lb_oe ? lb : 1'bx;
    sro_readout u_dut (
        .core_clk(core_clk), .nrst(nrst), .core_ce(1'b1),
        .convert_start_p(cs_p), .convert_start_n(cs_n),
        .power_down_n(power_down_n), .pattern_select(pattern_select),
        .dual_lane_select(dual_lane_select), .sampled_code(sampled_code),
        .shift_clk(sclk), .echoed_data_clock(echo), .echoed_data_clock_oe(echo_oe),
        .lane_a_data(la), .lane_a_oe(la_oe), .lane_b_data(lb), .lane_b_oe(lb_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    sro_host_model u_host (
        .convert_start_p(cs_p), .convert_start_n(cs_n), .shift_clk(sclk),
        .echoed_data_clock(echo), .lane_a_w(la_w), .lane_b_w(lb_w), .got_q(got)
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // axi4-lite write: both channels offered, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge core_clk);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    // axi4-lite read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // one conversion; the code moves on after the strobe
    task automatic conv(input logic [15:0] c, input logic dual, input logic diff,
                        input logic [15:0] exp);
        @(posedge core_clk);
        sampled_code <= c;
        dual_lane_select <= dual;
        repeat (6) @(posedge core_clk);
        fork
            u_host.frame(dual, diff);
            begin
                repeat (10) @(posedge core_clk);
                sampled_code <= ~c;
            end
        join
        check("frame word", 32'(got), 32'(exp));
    endtask : conv
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        fork
            u_host.pulses(2);
            repeat (8) @(posedge core_clk);
        join
        nrst <= 1'b1;
        axi_rd(`SRO_ADDR_CTRL, rd, rs);
        check("ctrl reset", rd, `SRO_CTRL_RESET);
        axi_rd(8'h10, rd, rs);
        check("unmapped resp", 32'(rs), 32'(`SRO_RESP_SLVERR));
        check("unmapped data", rd, 32'h0000_0000);
        axi_wr(`SRO_ADDR_STATUS, 32'h0000_0000, rs);
        check("ro write resp", 32'(rs), 32'(`SRO_RESP_OKAY));
        for (int i = 0; i < 4; i++) begin
            conv(codes[i], i[0], i[1], codes[i]);
        end
        axi_rd(`SRO_ADDR_RESULT, rd, rs);
        check("result", rd, 32'(codes[3]));
        axi_rd(`SRO_ADDR_STATUS, rd, rs);
        check("status", rd, 32'h0000_000E);
        @(posedge core_clk);
        pattern_select <= 1'b1;
        conv(16'h1357, 1'b0, 1'b1, `SRO_TEST_PATTERN);
        @(posedge core_clk);
        pattern_select <= 1'b0;
        axi_wr(`SRO_ADDR_CTRL, 32'h0000_0003, rs);
        conv(16'h2468, 1'b1, 1'b0, `SRO_TEST_PATTERN);
        axi_wr(`SRO_ADDR_CTRL, 32'h0000_0000, rs);
        u_host.frame(1'b0, 1'b0);
        axi_rd(`SRO_ADDR_COUNT, rd, rs);
        check("count disabled", rd, 32'h0000_0006);
        axi_wr(`SRO_ADDR_CTRL, `SRO_CTRL_RESET, rs);
        conv(16'h2468, 1'b0, 1'b0, 16'h2468);
        axi_rd(`SRO_ADDR_COUNT, rd, rs);
        check("count", rd, 32'h0000_0007);
        @(posedge core_clk);
        power_down_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        axi_rd(`SRO_ADDR_STATUS, rd, rs);
        check("powered bit", rd, 32'h0000_0000);
        u_host.frame(1'b0, 1'b1);
        check("frame in power down", 32'(got), 32'h0000_2468);
        axi_rd(`SRO_ADDR_COUNT, rd, rs);
        check("count in power down", rd, 32'h0000_0007);
        @(posedge core_clk);
        power_down_n <= 1'b1;
        conv(16'h0F0F, 1'b0, 1'b1, 16'h0F0F);
        summarize();
    end
endmodule : testbench
